// *** design/dbg_reg_file.sv ***
`timescale 1ns/1ns
module dbg_reg_file
   import tile_status_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // write port
   input  wire dbg_wr_s              wr,
   // read port, data one cycle after the index
   input  wire logic [DBG_IDX_W-1:0] rdIdx,
   output logic      [DATA_W-1:0]    rdData
);

   // storage words
   logic [DATA_W-1:0] mem_r [DBG_WORDS];

   // per-word, per-byte write with lane strobes
   genvar gw, gb;
   generate
      for (gw = 0; gw < DBG_WORDS; gw++) begin : g_word
         for (gb = 0; gb < STRB_W; gb++) begin : g_byte
            always_ff @(posedge clk or posedge rst) begin
               if (rst) begin
                  mem_r[gw][gb*8 +: 8] <= DBG_RST[gb*8 +: 8];
               end else if (wr.en && wr.idx == gw && wr.strb[gb]) begin
                  mem_r[gw][gb*8 +: 8] <= wr.data[gb*8 +: 8];
               end
            end
         end
      end
   endgenerate

   // registered read; a same-cycle write shows on the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData <= DBG_RST;
      end else begin
         rdData <= mem_r[rdIdx];
      end
   end

endmodule : dbg_reg_file

// *** design/tile_status_config_regs.sv ***
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Overview of operation
// - memory origin resets to 0x00040000
// - memory origin bits 31:2 writable, 1:0 reserved
// - destination = vector base upper, event vector lower
// - vector base field bits 31:18, rest reserved
// - bits 25:18 hold transmit data delay
// - transmit clock divider high/low compare points
// - bit 8 enables the RGMII ports
// - dynamic mode divides only when threads paused
// - static mode divides continuously
// - bit 4 enables low-power clock divider
// - bit 2 selects UTMI or ULPI
// - bit 1 enables ULPI support module
// - data watchpoint registers, debug mode access
// - resource breakpoint registers, debug mode access
module tile_status_config_regs
   import tile_status_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [STRB_W-1:0] s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // core status
   input  wire logic              debugMode,
   input  wire logic              allThreadsPaused,
   // event dispatch
   input  wire logic              eventTaken,
   input  wire logic [15:0]       eventVector,
   output logic [DATA_W-1:0]      destAddr,
   output logic                   destValid,
   // memory base seen by the core
   output logic [DATA_W-1:0]      memBase,
   // rgmii controls
   output logic                   rgmiiEnable,
   output logic [TX_DELAY_W-1:0]  rgmiiTxDelay,
   output logic                   rgmiiTxClk,
   output logic                   rgmiiTxLaunch,
   // low-power clock divider
   output logic                   coreClkDivActive,
   // usb controls
   output logic                   usbUtmiSelect,
   output logic                   usbUlpiEnable
);

   // writable registers
   logic [DATA_W-1:0]    memOrigin_r;     // memory base word address
   logic [DATA_W-1:0]    vectorBase_r;    // event vector upper bits
   logic [DATA_W-1:0]    tileCtrl_r;      // feature control word
   tile_ctrl_s           ctrl;            // field view of tileCtrl_r

   // write channel state
   logic                 awHave_r;        // write address captured
   logic                 wHave_r;         // write data captured
   logic [ADDR_W-1:0]    awAddr_r;        // captured write address
   logic [DATA_W-1:0]    wData_r;         // captured write data
   logic [STRB_W-1:0]    wStrb_r;         // captured lane strobes
   logic                 bvalid_r;
   logic [1:0]           bresp_r;
   logic                 doWrite;         // both halves present
   reg_sel_e             wrSel;
   dbg_wr_s              dbgWr;

   // read channel state
   typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} rd_state_e;
   rd_state_e            rdState_r;
   reg_sel_e             rdSel_r;         // target chosen at address time
   logic                 rdErr_r;         // refused at address time
   logic [DATA_W-1:0]    rdata_r;
   logic [1:0]           rresp_r;
   logic [DBG_IDX_W-1:0] memRdIdx;
   logic [DATA_W-1:0]    memRdData;

   // divider and delay state
   logic [TX_DIV_W-1:0]   txCnt_r;        // transmit clock phase counter
   logic                  txClk_r;
   logic [TX_DELAY_W-1:0] delayCnt_r;     // launch delay countdown
   logic                  delayPend_r;
   logic                  launch_r;
   logic                  txRise;         // counter at the rise point
   logic                  divActive_r;
   logic [DATA_W-1:0]     destAddr_r;
   logic                  destValid_r;

   // map a byte address to its register; misaligned is unmapped
   function automatic reg_sel_e decodeAddr(input logic [ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[ADDR_W-1:2];
      if (a[1:0] != 2'h0) begin
         return SEL_NONE;
      end
      unique case (idx)
         IDX_MEM_ORIGIN: return SEL_MEM_ORIGIN;
         IDX_VECTOR:     return SEL_VECTOR;
         IDX_TILE_CTRL:  return SEL_TILE_CTRL;
         IDX_IBRK_ADDR, IDX_IBRK_CTRL, IDX_DW_ADDR_A, IDX_DW_ADDR_B,
         IDX_DW_CTRL, IDX_RB_MASK, IDX_RB_VALUE, IDX_RB_CTRL:
                         return SEL_DEBUG;
         default:        return SEL_NONE;
      endcase
   endfunction : decodeAddr

   // slot of a debug register inside the storage
   function automatic logic [DBG_IDX_W-1:0] debugSlot(input logic [ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[ADDR_W-1:2];
      unique case (idx)
         IDX_IBRK_CTRL: return 3'h1;
         IDX_DW_ADDR_A: return 3'h2;
         IDX_DW_ADDR_B: return 3'h3;
         IDX_DW_CTRL:   return 3'h4;
         IDX_RB_MASK:   return 3'h5;
         IDX_RB_VALUE:  return 3'h6;
         IDX_RB_CTRL:   return 3'h7;
         default:       return 3'h0;
      endcase
   endfunction : debugSlot

   // byte-lane merge limited to the writable bits
   function automatic logic [DATA_W-1:0] mergeWrite(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] wd,
                                                    input logic [STRB_W-1:0] st,
                                                    input logic [DATA_W-1:0] keep);
      logic [DATA_W-1:0] lanes;
      lanes = '0;
      for (int i = 0; i < STRB_W; i++) begin
         lanes[i*8 +: 8] = {8{st[i]}};
      end
      return ((old & ~lanes) | (wd & lanes)) & keep;
   endfunction : mergeWrite

   // field view of the control word
   assign ctrl.txDelay = tileCtrl_r[TX_DELAY_LSB +: TX_DELAY_W];
   assign ctrl.txDiv   = tileCtrl_r[TX_DIV_LSB +: TX_DIV_W];
   assign ctrl.rgmiiEn = tileCtrl_r[RGMII_EN_BIT];
   assign ctrl.dynMode = tileCtrl_r[DYN_MODE_BIT];
   assign ctrl.divEn   = tileCtrl_r[DIV_EN_BIT];
   assign ctrl.utmiSel = tileCtrl_r[UTMI_SEL_BIT];
   assign ctrl.usbEn   = tileCtrl_r[USB_EN_BIT];

   // write commits once both address and data are held
   assign doWrite = awHave_r && wHave_r && !bvalid_r;
   assign wrSel   = decodeAddr(awAddr_r);

   // address and data channels taken in either order
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awHave_r <= 1'b0;
         awAddr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHave_r <= 1'b1;
         awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
         awHave_r <= 1'b0;
      end
   end

   // data half of the write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wHave_r <= 1'b0;
         wData_r <= '0;
         wStrb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHave_r <= 1'b1;
         wData_r <= s_axi_wdata;
         wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
         wHave_r <= 1'b0;
      end
   end

   // ready only while the slot is empty
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !(awHave_r || (s_axi_awvalid && s_axi_awready)) || doWrite;
         s_axi_wready  <= !(wHave_r || (s_axi_wvalid && s_axi_wready)) || doWrite;
      end
   end

   // write response; debug writes outside debug mode are refused
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid_r <= 1'b1;
         if (wrSel == SEL_NONE || (wrSel == SEL_DEBUG && !debugMode)) begin
            bresp_r <= RESP_SLVERR;
         end else begin
            bresp_r <= RESP_OKAY;
         end
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // memory origin register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         memOrigin_r <= MEM_ORIGIN_RST;
      end else if (doWrite && wrSel == SEL_MEM_ORIGIN) begin
         memOrigin_r <= mergeWrite(memOrigin_r, wData_r, wStrb_r, MEM_ORIGIN_MASK);
      end
   end

   // vector base register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vectorBase_r <= VECTOR_RST;
      end else if (doWrite && wrSel == SEL_VECTOR) begin
         vectorBase_r <= mergeWrite(vectorBase_r, wData_r, wStrb_r, VECTOR_MASK);
      end
   end

   // tile feature control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tileCtrl_r <= TILE_CTRL_RST;
      end else if (doWrite && wrSel == SEL_TILE_CTRL) begin
         tileCtrl_r <= mergeWrite(tileCtrl_r, wData_r, wStrb_r, TILE_CTRL_MASK);
      end
   end

   // debug storage write request
   always_comb begin
      dbgWr      = '0;
      dbgWr.en   = doWrite && wrSel == SEL_DEBUG && debugMode;
      dbgWr.idx  = debugSlot(awAddr_r);
      dbgWr.data = wData_r;
      dbgWr.strb = wStrb_r;
   end

   // read index follows the address bus while idle
   assign memRdIdx = debugSlot(s_axi_araddr);

   // breakpoint and watchpoint storage
   dbg_reg_file u_dbg (
      .clk    (clk),
      .rst    (rst),
      .wr     (dbgWr),
      .rdIdx  (memRdIdx),
      .rdData (memRdData)
   );

   // read sequencer: take address, wait for storage, answer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdState_r     <= RD_IDLE;
         s_axi_arready <= 1'b0;
         rdSel_r       <= SEL_NONE;
         rdErr_r       <= 1'b0;
      end else begin
         unique case (rdState_r)
            RD_IDLE: begin
               s_axi_arready <= 1'b1;
               if (s_axi_arvalid && s_axi_arready) begin
                  s_axi_arready <= 1'b0;
                  rdSel_r       <= decodeAddr(s_axi_araddr);
                  rdErr_r       <= decodeAddr(s_axi_araddr) == SEL_NONE ||
                                   (decodeAddr(s_axi_araddr) == SEL_DEBUG && !debugMode);
                  rdState_r     <= RD_FETCH;
               end
            end
            RD_FETCH: begin
               rdState_r <= RD_RESP;
            end
            RD_RESP: begin
               // hold until the master takes it
               if (s_axi_rready) begin
                  rdState_r <= RD_IDLE;
               end
            end
         endcase
      end
   end

   // read data and response, captured as fetch ends
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r      <= '0;
         rresp_r      <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
      end else if (rdState_r == RD_FETCH) begin
         s_axi_rvalid <= 1'b1;
         rresp_r      <= rdErr_r ? RESP_SLVERR : RESP_OKAY;
         // refused and unmapped reads return zero
         if (rdErr_r) begin
            rdata_r <= '0;
         end else begin
            unique case (rdSel_r)
               SEL_MEM_ORIGIN: rdata_r <= memOrigin_r;
               SEL_VECTOR:     rdata_r <= vectorBase_r;
               SEL_TILE_CTRL:  rdata_r <= tileCtrl_r;
               SEL_DEBUG:      rdata_r <= memRdData;
               SEL_NONE:       rdata_r <= '0;
            endcase
         end
      end else if (rdState_r == RD_RESP && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // event destination address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         destAddr_r  <= '0;
         destValid_r <= 1'b0;
      end else begin
         destValid_r <= eventTaken;
         if (eventTaken) begin
            // upper half from base, lower from vector
            destAddr_r <= {vectorBase_r[DATA_W-1:VEC_HALF], eventVector};
         end
      end
   end

   // transmit clock counter; clk stands in for the pll output
   // ratio minus one is what the counter wraps at
   assign txRise = txCnt_r == ctrl.txDiv;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txCnt_r <= '0;
      end else if (!ctrl.rgmiiEn || txCnt_r >= ctrl.txDiv) begin
         txCnt_r <= '0;
      end else begin
         txCnt_r <= txCnt_r + 9'h001;
      end
   end

   // transmit clock edges; rise wins when both points meet
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txClk_r <= 1'b0;
      end else if (!ctrl.rgmiiEn) begin
         txClk_r <= 1'b0;
      end else if (txRise) begin
         txClk_r <= 1'b1;
      end else if (txCnt_r == (ctrl.txDiv >> 1)) begin
         txClk_r <= 1'b0;
      end
   end

   // data launch delayed from each clock rise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         delayCnt_r  <= '0;
         delayPend_r <= 1'b0;
         launch_r    <= 1'b0;
      end else begin
         launch_r <= 1'b0;
         if (!ctrl.rgmiiEn) begin
            delayPend_r <= 1'b0;
         end else if (txRise) begin
            if (ctrl.txDelay == 8'h00) begin
               launch_r    <= 1'b1;
               delayPend_r <= 1'b0;
            end else begin
               delayCnt_r  <= ctrl.txDelay - 8'h01;
               delayPend_r <= 1'b1;
            end
         end else if (delayPend_r) begin
            if (delayCnt_r == 8'h00) begin
               launch_r    <= 1'b1;
               delayPend_r <= 1'b0;
            end else begin
               delayCnt_r <= delayCnt_r - 8'h01;
            end
         end
      end
   end

   // low-power divider engage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divActive_r <= 1'b0;
      end else if (!ctrl.divEn) begin
         divActive_r <= 1'b0;
      end else if (ctrl.dynMode) begin
         divActive_r <= allThreadsPaused;
      end else begin
         divActive_r <= 1'b1;
      end
   end

   // outputs, each from a flip-flop
   assign s_axi_bvalid     = bvalid_r;
   assign s_axi_bresp      = bresp_r;
   assign s_axi_rdata      = rdata_r;
   assign s_axi_rresp      = rresp_r;
   assign destAddr         = destAddr_r;
   assign destValid        = destValid_r;
   assign memBase          = memOrigin_r;
   assign rgmiiEnable      = tileCtrl_r[RGMII_EN_BIT];
   assign rgmiiTxDelay     = tileCtrl_r[TX_DELAY_LSB +: TX_DELAY_W];
   assign rgmiiTxClk       = txClk_r;
   assign rgmiiTxLaunch    = launch_r;
   assign coreClkDivActive = divActive_r;
   assign usbUtmiSelect    = tileCtrl_r[UTMI_SEL_BIT];
   assign usbUlpiEnable    = tileCtrl_r[USB_EN_BIT];

endmodule : tile_status_config_regs

// *** inc/tile_status_pkg.sv ***
package tile_status_pkg;

   // bus geometry
   localparam int          ADDR_W          = 10;
   localparam int          DATA_W          = 32;
   localparam int          STRB_W          = 4;

   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_MEM_ORIGIN  = 8'h00;
   localparam logic [7:0]  IDX_VECTOR      = 8'h01;
   localparam logic [7:0]  IDX_TILE_CTRL   = 8'h02;
   localparam logic [7:0]  IDX_IBRK_ADDR   = 8'h30;
   localparam logic [7:0]  IDX_IBRK_CTRL   = 8'h40;
   localparam logic [7:0]  IDX_DW_ADDR_A   = 8'h50;
   localparam logic [7:0]  IDX_DW_ADDR_B   = 8'h60;
   localparam logic [7:0]  IDX_DW_CTRL     = 8'h70;
   localparam logic [7:0]  IDX_RB_MASK     = 8'h80;
   localparam logic [7:0]  IDX_RB_VALUE    = 8'h90;
   localparam logic [7:0]  IDX_RB_CTRL     = 8'h9C;

   // debug storage geometry
   localparam int          DBG_WORDS       = 8;
   localparam int          DBG_IDX_W       = 3;
   localparam logic [31:0] DBG_RST         = 32'h00000000;

   // reset values and writable masks
   localparam logic [31:0] MEM_ORIGIN_RST  = 32'h00040000;
   localparam logic [31:0] MEM_ORIGIN_MASK = 32'hFFFFFFFC;
   localparam logic [31:0] VECTOR_RST      = 32'h00000000;
   localparam logic [31:0] VECTOR_MASK     = 32'hFFFC0000;
   localparam logic [31:0] TILE_CTRL_RST   = 32'h00000000;
   localparam logic [31:0] TILE_CTRL_MASK  = 32'h03FFFF36;

   // tile control field positions
   localparam int          TX_DELAY_LSB    = 18;
   localparam int          TX_DELAY_W      = 8;
   localparam int          TX_DIV_LSB      = 9;
   localparam int          TX_DIV_W        = 9;
   localparam int          RGMII_EN_BIT    = 8;
   localparam int          DYN_MODE_BIT    = 5;
   localparam int          DIV_EN_BIT      = 4;
   localparam int          UTMI_SEL_BIT    = 2;
   localparam int          USB_EN_BIT      = 1;

   // vector address split
   localparam int          VEC_HALF        = 16;

   // bus responses
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // register selection after decode
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_MEM_ORIGIN,
      SEL_VECTOR,
      SEL_TILE_CTRL,
      SEL_DEBUG
   } reg_sel_e;

   // write request into the debug storage
   typedef struct packed {
      logic                 en;
      logic [DBG_IDX_W-1:0] idx;
      logic [DATA_W-1:0]    data;
      logic [STRB_W-1:0]    strb;
   } dbg_wr_s;

   // decoded view of tile control
   typedef struct packed {
      logic [TX_DELAY_W-1:0] txDelay;
      logic [TX_DIV_W-1:0]   txDiv;
      logic                  rgmiiEn;
      logic                  dynMode;
      logic                  divEn;
      logic                  utmiSel;
      logic                  usbEn;
   } tile_ctrl_s;

endpackage : tile_status_pkg

// *** test/testbench.sv ***
`timescale 1ns/1ns
module testbench
   import tile_status_pkg::*;
;
   // driven inputs
   logic clk = 0, rst = 1, debugMode = 0, allThreadsPaused = 0, eventTaken = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]       s_axi_wdata = '0;
   logic [3:0]        s_axi_wstrb = 4'hF;
   logic [15:0]       eventVector = '0;
   // observed outputs
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, destValid;
   logic rgmiiEnable, rgmiiTxClk, rgmiiTxLaunch, coreClkDivActive, usbUtmiSelect, usbUlpiEnable;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, destAddr, memBase;
   logic [7:0]  rgmiiTxDelay;
   // bookkeeping
   int miscompares = 0, checked = 0, k, kh, kl;
   logic prev;
   logic [7:0] dbgIdx [8] = '{8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'h9C};

   tile_status_config_regs i_dut (.*);

   initial begin
      forever #20 clk = ~clk;
   end

   task automatic end_sim;
      if (miscompares == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk

   // a used-up wait ends the run
   task automatic hang(input int n);
      if (n >= 60) begin
         miscompares++;
         end_sim();
      end
   endtask : hang

   // each half released when taken; one idle edge after so no signal is set twice
   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr  <= {idx, 2'h0};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid && n < 60);
      hang(n);
      chk(32'(s_axi_bresp), 32'(er));
      s_axi_bready <= 1'h0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr  <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid && n < 60);
      hang(n);
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'h0;
      @(posedge clk);
   endtask : rd

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      rd(8'h00, 32'h00040000, 2'h0);
      rd(8'h02, 32'h00000000, 2'h0);
      chk(32'({rgmiiEnable, usbUtmiSelect, usbUlpiEnable, coreClkDivActive}), 32'h0);
      wr(8'h00, 32'hFFFFFFFF, 2'h0);
      rd(8'h00, 32'hFFFFFFFC, 2'h0);
      chk(memBase, 32'hFFFFFFFC);
      wr(8'h01, 32'hFFFFFFFF, 2'h0);
      rd(8'h01, 32'hFFFC0000, 2'h0);
      // event sampled at one edge, answer stands the next cycle
      eventVector <= 16'h1234;
      eventTaken  <= 1'h1;
      @(posedge clk);
      eventTaken <= 1'h0;
      @(posedge clk);
      chk({destAddr[31:1], destValid}, 32'hFFFC1235);
      wr(8'h02, 32'hFFFFFFFF, 2'h0);
      rd(8'h02, 32'h03FFFF36, 2'h0);
      chk(32'({rgmiiTxDelay, rgmiiEnable, usbUtmiSelect, usbUlpiEnable}), 32'h7FF);
      wr(8'h02, 32'h00000004, 2'h0);
      chk(32'({usbUtmiSelect, usbUlpiEnable}), 32'h2);
      wr(8'h02, 32'h00000002, 2'h0);
      chk(32'({usbUtmiSelect, usbUlpiEnable}), 32'h1);
      // static divides with threads running, dynamic waits for pause
      wr(8'h02, 32'h00000010, 2'h0);
      chk(32'(coreClkDivActive), 32'h1);
      wr(8'h02, 32'h00000030, 2'h0);
      chk(32'(coreClkDivActive), 32'h0);
      allThreadsPaused <= 1'h1;
      repeat (2) @(posedge clk);
      chk(32'(coreClkDivActive), 32'h1);
      wr(8'h02, 32'h00000000, 2'h0);
      chk(32'(coreClkDivActive), 32'h0);
      // divide by four: field holds three, so ten rises in forty cycles, high half the time;
      // a delay of two puts each launch two cycles after the rise, on the fall
      wr(8'h02, 32'h00080700, 2'h0);
      k = 0;
      kh = 0;
      kl = 0;
      // one edge for the counter to settle into its period
      @(posedge clk);
      prev = rgmiiTxClk;
      repeat (40) begin
         @(posedge clk);
         if (rgmiiTxClk && !prev) k++;
         if (rgmiiTxClk) kh++;
         if (rgmiiTxLaunch && !rgmiiTxClk && prev) kl++;
         prev = rgmiiTxClk;
      end
      chk(32'(k), 32'hA);
      chk(32'(kh), 32'h14);
      chk(32'(kl), 32'hA);
      // debug words refused outside debug mode
      wr(8'h70, 32'hA5A5A5A5, 2'h2);
      rd(8'h9C, 32'h0, 2'h2);
      debugMode <= 1'h1;
      @(posedge clk);
      // the refused write above must not have landed
      rd(8'h70, 32'h0, 2'h0);
      foreach (dbgIdx[i]) wr(dbgIdx[i], {dbgIdx[i], 24'hC3C3C3}, 2'h0);
      foreach (dbgIdx[i]) rd(dbgIdx[i], {dbgIdx[i], 24'hC3C3C3}, 2'h0);
      wr(8'h03, 32'h12345678, 2'h2);
      rd(8'h03, 32'h0, 2'h2);
      // second reset in mid-run
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      rd(8'h00, 32'h00040000, 2'h0);
      end_sim();
   end
endmodule : testbench

// *** test/tile_status_props.sv ***
`timescale 1ns/1ns
module tile_status_props
   import tile_status_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // event path, memory base and transmit clock
   input wire logic        eventTaken,
   input wire logic [15:0] eventVector,
   input wire logic [31:0] destAddr,
   input wire logic        destValid,
   input wire logic [31:0] memBase,
   input wire logic        rgmiiTxClk
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_origin_reset: assert property ($fell(rst) |-> memBase == 32'h00040000)
      else $error("origin wrong after reset");
   a_origin_low: assert property (memBase[1:0] == 2'h0)
      else $error("origin low bits set");
   a_dest_lower: assert property (eventTaken |=> destValid && destAddr[15:0] == $past(eventVector))
      else $error("dest lower half wrong");
   a_dest_single: assert property (!eventTaken |=> !destValid)
      else $error("dest valid without event");
   a_dest_reserved: assert property (destValid |-> destAddr[17:16] == 2'h0)
      else $error("dest reserved bits set");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[1:2] s_axi_rvalid)
      else $error("read answer late");
   a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
      else $error("read not released");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                                    |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");

   // main scenarios
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_event: cover property (destValid);
   c_txclk: cover property ($rose(rgmiiTxClk));
endmodule : tile_status_props

bind tile_status_config_regs tile_status_props i_props (.*);
